/* dssm_regs.vh */
// Constants for the display source select and monitor block
`ifndef DSSM_REGS_VH
`define DSSM_REGS_VH
// =====================================================
// APB register map (byte addresses)
`define DSSM_ADDR_CTRL 12'h000
`define DSSM_ADDR_STAT 12'h004
`define DSSM_ADDR_WORD 12'h008
`define DSSM_ADDR_LATCH 12'h00C
`define DSSM_ADDR_BITS 12
// CTRL fields
`define DSSM_CTRL_EXT 0
`define DSSM_CTRL_CHECK 1
`define DSSM_CTRL_IN 2
`define DSSM_CTRL_PRES 3
`define DSSM_CTRL_RECALL 4
`define DSSM_CTRL_INHIBIT 5
`define DSSM_CTRL_SAVED 6
`define DSSM_CTRL_WIDTH 7
// STAT fields
`define DSSM_STAT_CODE_LO 0
`define DSSM_STAT_CODE_HI 2
`define DSSM_STAT_FAULT 3
`define DSSM_STAT_PANEL_DIS 4
`define DSSM_STAT_CLK_ALT 5
// =====================================================
// Selector codes
`define DSSM_SEL_EXT 3'h1
`define DSSM_SEL_CHECK 3'h3
`define DSSM_SEL_IN 3'h5
`define DSSM_SEL_PRES 3'h6
`define DSSM_SEL_RECALL 3'h7
`define DSSM_SEL_NONE 3'h0
// =====================================================
// Frame layout
`define DSSM_SYNC_MASK 8'hFC
`define DSSM_SYNC_VAL 8'h7C
`define DSSM_FRAME_COUNT 40
`define DSSM_CNT_BITS 6
`define DSSM_WORD_BITS 32
// Word 0 id bits inside the shift register, and fields of the latch
`define DSSM_ID_LO 12
`define DSSM_ID_HI 15
`define DSSM_BIT_FCE 31
`define DSSM_USER_LO 16
`define DSSM_USER_HI 19
// =====================================================
// Timing
`define DSSM_CLK_NS 10
`define DSSM_STROBE_NS 5000
`define DSSM_CLKLOSS_NS 4000
`endif

/* dssm_framer.v */
// Sync code detector and 40-period frame-end counter
`timescale 1ns/1ns
`include "dssm_regs.vh"
module dssm_framer #(
   parameter CNT = `DSSM_FRAME_COUNT
) (
   input wire clock_in,
   input wire nrst_in,
   input wire bit_tick_in,
   input wire data_in,
   output reg frame_end_out,
   output reg spurious_out
);
   reg [7:0] shift_reg;
   reg run_reg;
   reg [`DSSM_CNT_BITS-1:0] cnt_reg;
   wire [7:0] shift_next;
   wire five_ones;
   wire sync_ok;
   assign shift_next = {shift_reg[6:0], data_in};
   // Oldest bit first: 0 then five ones, then 01 or 10
   assign five_ones = (shift_next[5:0] == 6'h1F);
   assign sync_ok = ((shift_next & `DSSM_SYNC_MASK) == `DSSM_SYNC_VAL)
      && (shift_next[1] ^ shift_next[0]);
   always @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         shift_reg <= 8'h00;
         run_reg <= 1'b0;
         cnt_reg <= {`DSSM_CNT_BITS{1'b0}};
         frame_end_out <= 1'b0;
         spurious_out <= 1'b0;
      end else begin
         frame_end_out <= 1'b0;
         spurious_out <= 1'b0;
         if (bit_tick_in) begin
            shift_reg <= shift_next;
            if (sync_ok) begin
               run_reg <= 1'b1;
               cnt_reg <= {`DSSM_CNT_BITS{1'b0}};
            end else if (run_reg && five_ones) begin
               run_reg <= 1'b0;
               spurious_out <= 1'b1;
            end else if (run_reg) begin
               if (cnt_reg == CNT[`DSSM_CNT_BITS-1:0] - 6'h01) begin
                  run_reg <= 1'b0;
                  frame_end_out <= 1'b1;
               end else begin
                  cnt_reg <= cnt_reg + 6'h01;
               end
            end
         end
      end
   end
endmodule // dssm_framer

/* dssm_top.v */
// Display source selector, strobe generator and revertive monitor
// Operation
// - fixed priority recall preserve in check external
// - three-bit code, valid bit, two-bit select
// - invalid code blocks data and clock
// - select code routes one source pair
// - check in recall raise preserve
// - check waits for save, panel disabled
// - in waits for save then transfer
// - recall saves, routes store, self-clears
// - low strobe at frame end, gated
// - header zero, five ones, 01/10
// - forty bits after header, frame end
// - revertive data into 32-bit shifter
// - word 0 at frame end loads latch
// - word 0 when id bits zero
// - monitor has own detector and counter
// - display inhibit delayed two frames
// - line fault from three causes
// - indicators from latched word bits
// - user bits on open-collector outputs
// - control clock replaces absent revertive
// - data-present gates revertive clock off
// - external data uses control clock
// - stray five ones cancels frame end
// - frame end clears check and recall
`timescale 1ns/1ns
`include "dssm_regs.vh"
module dssm_top #(
   parameter STROBE_CYC = (`DSSM_STROBE_NS + `DSSM_CLK_NS - 1) / `DSSM_CLK_NS,
   parameter LOSS_CYC = `DSSM_CLKLOSS_NS / `DSSM_CLK_NS
) (
   input wire clock_in,
   input wire nrst_in,
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [`DSSM_ADDR_BITS-1:0] paddr_in,
   input wire [31:0] pwdata_in,
   output reg [31:0] prdata_out,
   output wire pready_out,
   output wire pslverr_out,
   input wire source_data_channel_zero_in,
   input wire rev_data_in,
   input wire xfer_data_in,
   input wire store_data_in,
   input wire ctrl_clk_in,
   input wire rev_clk_in,
   input wire xfer_clk_in,
   input wire rev_data_absent_in,
   output reg disp_data_out,
   output reg disp_clk_out,
   output reg disp_strobe_n_out,
   output reg monitor_load_out,
   output reg line_fault_out,
   output reg [7:0] indicators_out,
   output wire [3:0] user_fn_out,
   output wire [3:0] user_fn_oe_out,
   output wire panel_disable_out
);
   // =====================================================
   // Pin synchronisers
   // All link pins are asynchronous to clock_in: two stages each,
   // and only the second stage is read by any logic.
   reg [6:0] s1_reg;
   reg [6:0] s2_reg;
   always @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s1_reg <= 7'h00;
         s2_reg <= 7'h00;
      end else begin
         s1_reg <= {rev_data_absent_in, xfer_clk_in, rev_clk_in,
            ctrl_clk_in, store_data_in, xfer_data_in, rev_data_in};
         s2_reg <= s1_reg;
      end
   end
   wire s_data_rev = s2_reg[0];
   wire s_data_xfer = s2_reg[1];
   wire s_data_store = s2_reg[2];
   wire s_clk_ctrl = s2_reg[3];
   wire s_clk_rev = s2_reg[4];
   wire s_clk_xfer = s2_reg[5];
   wire s_gate_off = s2_reg[6];
   reg s_ext_reg;
   reg s_ext2_reg;
   always @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s_ext_reg <= 1'b0;
         s_ext2_reg <= 1'b0;
      end else begin
         s_ext_reg <= source_data_channel_zero_in;
         s_ext2_reg <= s_ext_reg;
      end
   end
   // =====================================================
   // Revertive clock presence and substitution
   reg [3:0] clk_d_reg;
   reg [15:0] loss_reg;
   wire rev_edge = s_clk_rev & ~clk_d_reg[0];
   wire rev_present = (loss_reg < LOSS_CYC[15:0]);
   always @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         clk_d_reg <= 4'h0;
         loss_reg <= 16'hFFFF;
      end else begin
         clk_d_reg <= {s_clk_xfer, s_clk_ctrl, s_clk_rev, s_clk_rev};
         if (rev_edge)
            loss_reg <= 16'h0000;
         else if (loss_reg != 16'hFFFF)
            loss_reg <= loss_reg + 16'h0001;
      end
   end
   wire ctrl_clk = s_clk_ctrl;
   wire ctrl_edge = s_clk_ctrl & ~clk_d_reg[2];
   wire xfer_edge = s_clk_xfer & ~clk_d_reg[3];
   // data-present input gates clock
   // The edge that ends an absence already counts as revertive, so
   // the first bit after a quiet spell is not lost to the substitute.
   // Limitation: a control edge in that same cycle is dropped instead.
   wire rev_live = rev_present | rev_edge;
   wire mon_clk = s_gate_off ? 1'b0 : (rev_live ? s_clk_rev : ctrl_clk);
   wire mon_edge = s_gate_off ? 1'b0 : (rev_live ? rev_edge : ctrl_edge);
   // =====================================================
   // Control register and select latches
   reg [`DSSM_CTRL_WIDTH-1:0] ctrl_reg;
   reg check_reg;
   reg recall_reg;
   reg pres_reg;
   reg disp_end;
   wire wr = psel_in & penable_in & pwrite_in;
   wire wr_ctrl = wr && (paddr_in == `DSSM_ADDR_CTRL);
   wire w_check = wr_ctrl & pwdata_in[`DSSM_CTRL_CHECK];
   wire sel_in = ctrl_reg[`DSSM_CTRL_IN];
   wire sel_ext = ctrl_reg[`DSSM_CTRL_EXT];
   // Only a fresh in request asks for a save; rewriting the bit
   // together with saved must not raise preserve again.
   wire w_in = wr_ctrl & pwdata_in[`DSSM_CTRL_IN] & ~sel_in;
   wire w_recall = wr_ctrl & pwdata_in[`DSSM_CTRL_RECALL];
   wire w_saved = wr_ctrl & pwdata_in[`DSSM_CTRL_SAVED];
   // Select latches are set by a one in the written word; the
   // display frame end clears check and recall, and a set wins.
   always @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ctrl_reg <= {`DSSM_CTRL_WIDTH{1'b0}};
         check_reg <= 1'b0;
         recall_reg <= 1'b0;
         pres_reg <= 1'b0;
      end else begin
         if (wr_ctrl)
            ctrl_reg <= pwdata_in[`DSSM_CTRL_WIDTH-1:0];
         if (w_check)
            check_reg <= 1'b1;
         else if (disp_end)
            check_reg <= 1'b0;
         if (w_recall)
            recall_reg <= 1'b1;
         else if (disp_end)
            recall_reg <= 1'b0;
         if (w_check | w_in | w_recall |
               (wr_ctrl & pwdata_in[`DSSM_CTRL_PRES]))
            pres_reg <= 1'b1;
         else if (w_saved | (recall_reg & disp_end))
            pres_reg <= 1'b0;
      end
   end
   // =====================================================
   // Priority encoder and source multiplexer
   // Levels 2 and 4 are unused, so neither is decoded
   reg [2:0] code;
   always @* begin
      if (recall_reg)
         code = `DSSM_SEL_RECALL;
      else if (pres_reg)
         code = `DSSM_SEL_PRES;
      else if (sel_in)
         code = `DSSM_SEL_IN;
      else if (check_reg)
         code = `DSSM_SEL_CHECK;
      else if (sel_ext)
         code = `DSSM_SEL_EXT;
      else
         code = `DSSM_SEL_NONE;
   end
   // low bit valid, upper bits select
   wire select_valid_bit = code[0];
   wire [1:0] sel2 = code[2:1];
   reg mux_d;
   reg mux_c;
   reg mux_e;
   always @* begin
      case (sel2)
         2'h0: begin
            mux_d = s_ext2_reg;
            mux_c = ctrl_clk;
            mux_e = ctrl_edge;
         end
         2'h1: begin
            mux_d = s_data_rev;
            mux_c = mon_clk;
            mux_e = mon_edge;
         end
         2'h2: begin
            mux_d = s_data_xfer;
            mux_c = s_clk_xfer;
            mux_e = xfer_edge;
         end
         default: begin
            mux_d = s_data_store;
            mux_c = ctrl_clk;
            mux_e = ctrl_edge;
         end
      endcase
   end
   wire disp_tick = select_valid_bit & mux_e;
   assign panel_disable_out = check_reg & pres_reg;
   // =====================================================
   // Display framer and strobe
   wire disp_end_w;
   dssm_framer u_disp (
      .clock_in(clock_in),
      .nrst_in(nrst_in),
      .bit_tick_in(disp_tick),
      .data_in(mux_d),
      .frame_end_out(disp_end_w),
      .spurious_out()
   );
   // Strobe length is counted in system clocks, so it follows
   // STROBE_CYC rather than the link rate.
   reg [15:0] strobe_reg;
   always @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         disp_data_out <= 1'b0;
         disp_clk_out <= 1'b0;
         disp_end <= 1'b0;
         strobe_reg <= 16'h0000;
         disp_strobe_n_out <= 1'b1;
      end else begin
         disp_data_out <= select_valid_bit & mux_d;
         disp_clk_out <= select_valid_bit & mux_c;
         disp_end <= disp_end_w & select_valid_bit;
         if (disp_end_w & select_valid_bit)
            strobe_reg <= STROBE_CYC[15:0];
         else if (strobe_reg != 16'h0000)
            strobe_reg <= strobe_reg - 16'h0001;
         disp_strobe_n_out <= ~((disp_end_w & select_valid_bit) |
            (strobe_reg > 16'h0001));
      end
   end
   // =====================================================
   // Revertive monitor path
   // separate monitor framer
   wire mon_end;
   wire mon_spur;
   dssm_framer u_mon (
      .clock_in(clock_in),
      .nrst_in(nrst_in),
      .bit_tick_in(mon_edge),
      .data_in(s_data_rev),
      .frame_end_out(mon_end),
      .spurious_out(mon_spur)
   );
   // Shifter and latch are one word wide; the latch holds until
   // the next accepted word 0.
   reg [`DSSM_WORD_BITS-1:0] word_reg;
   reg [`DSSM_WORD_BITS-1:0] latch_reg;
   reg [1:0] inh_reg;
   reg [15:0] hold_reg;
   always @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         word_reg <= {`DSSM_WORD_BITS{1'b0}};
         latch_reg <= {`DSSM_WORD_BITS{1'b0}};
         inh_reg <= 2'h0;
         monitor_load_out <= 1'b0;
         hold_reg <= 16'h0000;
         line_fault_out <= 1'b0;
         indicators_out <= 8'h00;
      end else begin
         if (mon_edge)
            word_reg <= {word_reg[`DSSM_WORD_BITS-2:0], s_data_rev};
         if (mon_end)
            inh_reg <= {inh_reg[0], ctrl_reg[`DSSM_CTRL_INHIBIT]};
         // load on word 0 at frame end
         monitor_load_out <= mon_end & ~inh_reg[1] &
            (word_reg[`DSSM_ID_HI:`DSSM_ID_LO] == 4'h0);
         if (monitor_load_out)
            latch_reg <= word_reg;
         // error bit, spurious sync, revertive clock loss
         // Hold stands in for the slow decay of the fault lamp, so a
         // single-cycle cause stays visible for STROBE_CYC + 1 cycles.
         if (latch_reg[`DSSM_BIT_FCE] | mon_spur | ~rev_present)
            hold_reg <= STROBE_CYC[15:0];
         else if (hold_reg != 16'h0000)
            hold_reg <= hold_reg - 16'h0001;
         line_fault_out <= latch_reg[`DSSM_BIT_FCE] | mon_spur |
            ~rev_present | (hold_reg != 16'h0000);
         indicators_out <= {latch_reg[31:28], latch_reg[25:23],
            latch_reg[21]};
      end
   end
   // user bits, open collector
   // Pin is pulled low while its enable is high
   assign user_fn_out = 4'h0;
   assign user_fn_oe_out = latch_reg[`DSSM_USER_HI:`DSSM_USER_LO];
   // =====================================================
   // APB read side, zero wait states
   // Every register answers in the access cycle; unmapped reads
   // give zero and unmapped writes are dropped.
   assign pready_out = 1'b1;
   assign pslverr_out = 1'b0;
   wire [31:0] stat_word;
   assign stat_word[`DSSM_STAT_CODE_HI:`DSSM_STAT_CODE_LO] = code;
   assign stat_word[`DSSM_STAT_FAULT] = line_fault_out;
   assign stat_word[`DSSM_STAT_PANEL_DIS] = panel_disable_out;
   assign stat_word[`DSSM_STAT_CLK_ALT] = ~rev_present;
   assign stat_word[31:`DSSM_STAT_CLK_ALT+1] = 26'h0;
   always @* begin
      case (paddr_in)
         `DSSM_ADDR_CTRL: prdata_out = {25'h0, ctrl_reg};
         `DSSM_ADDR_STAT: prdata_out = stat_word;
         `DSSM_ADDR_WORD: prdata_out = word_reg;
         `DSSM_ADDR_LATCH: prdata_out = latch_reg;
         default: prdata_out = 32'h0000_0000;
      endcase
   end
endmodule // dssm_top

/* dssm_top_assertions.sv */
// Port checker for the display source select block
`timescale 1ns/1ns
module dssm_top_assertions #(
   parameter STROBE_CYC = 500,
   parameter LOSS_CYC = 400
) (
   input wire clock_in,
   input wire nrst_in,
   input wire rev_clk_in,
   input wire disp_data_out,
   input wire disp_clk_out,
   input wire disp_strobe_n_out,
   input wire monitor_load_out,
   input wire line_fault_out,
   input wire [7:0] indicators_out,
   input wire [3:0] user_fn_oe_out,
   input wire panel_disable_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!nrst_in);
   // ========
   // Helper counters, wrap is harmless: it only hides a firing
   reg [15:0] low_reg;
   reg [15:0] gap_reg;
   reg [15:0] loss_reg;
   reg rclk_reg;
   always @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         low_reg <= 16'h0;
         gap_reg <= 16'h0;
         loss_reg <= 16'h0;
         rclk_reg <= 1'b0;
      end else begin
         low_reg <= disp_strobe_n_out ? 16'h0 : low_reg + 16'h1;
         gap_reg <= $rose(disp_clk_out) ? 16'h0 : gap_reg + 16'h1;
         loss_reg <= (rev_clk_in != rclk_reg) ? 16'h0 : loss_reg + 16'h1;
         rclk_reg <= rev_clk_in;
      end
   end
   // ========
   // Properties
   sequence held_s;
      panel_disable_out ##1 panel_disable_out;
   endsequence
   sequence pulse_s;
      monitor_load_out ##1 !monitor_load_out;
   endsequence
   reset_quiet_a: assert property (
      $rose(nrst_in) |-> disp_strobe_n_out && !monitor_load_out)
      else $error("strobe or load active after reset");
   load_pulse_a: assert property (
      monitor_load_out |-> pulse_s)
      else $error("load pulse longer than one cycle");
   strobe_width_a: assert property (
      $rose(disp_strobe_n_out) |->
      low_reg >= STROBE_CYC - 1 && low_reg <= STROBE_CYC + 1)
      else $error("strobe width wrong");
   strobe_after_bit_a: assert property (
      $fell(disp_strobe_n_out) |-> gap_reg < 16'h18)
      else $error("strobe without recent display bit");
   preserve_block_a: assert property (
      held_s |-> !disp_clk_out && !disp_data_out)
      else $error("display active while preserving");
   user_load_a: assert property (
      !$stable(user_fn_oe_out) |-> monitor_load_out ||
      $past(monitor_load_out) || $past(monitor_load_out, 2))
      else $error("user outputs changed without load");
   ind_load_a: assert property (
      !$stable(indicators_out) |-> $past(monitor_load_out) ||
      $past(monitor_load_out, 2) || $past(monitor_load_out, 3))
      else $error("indicators changed without load");
   error_fault_a: assert property (
      indicators_out[7] && $past(indicators_out[7]) |-> line_fault_out)
      else $error("error bit without line fault");
   loss_fault_a: assert property (
      loss_reg > LOSS_CYC + 8 |-> line_fault_out)
      else $error("clock loss without line fault");
endmodule // dssm_top_assertions
bind dssm_top dssm_top_assertions #(
   .STROBE_CYC(STROBE_CYC),
   .LOSS_CYC(LOSS_CYC)
) chk (
   .clock_in(clock_in),
   .nrst_in(nrst_in),
   .rev_clk_in(rev_clk_in),
   .disp_data_out(disp_data_out),
   .disp_clk_out(disp_clk_out),
   .disp_strobe_n_out(disp_strobe_n_out),
   .monitor_load_out(monitor_load_out),
   .line_fault_out(line_fault_out),
   .indicators_out(indicators_out),
   .user_fn_oe_out(user_fn_oe_out),
   .panel_disable_out(panel_disable_out)
);

/* dssm_serial_model.sv */
// Serial highway model: framed data on a gated link clock
`timescale 1ns/1ns
module dssm_serial_model (
   output logic clk_out,
   output logic data_out
);
   initial begin
      clk_out = 1'b0;
      data_out = 1'b1;
   end
   // ========
   // Frame sender, clock stands still between frames
   // sync, code, payload
   task automatic send(input logic [1:0] code, input logic [39:0] body);
      logic [47:0] f;
      f = {1'b0, 5'h1F, code, body};
      for (int i = 47; i >= 0; i--) begin
         data_out = f[i];
         #62 clk_out = 1'b1;
         #63 clk_out = 1'b0;
      end
      // Released line must not look like a held bit
      data_out = ~f[0];
   endtask
endmodule // dssm_serial_model

/* tb_display_source_select_and_monitor.sv */
// Self-checking bench for the display source select block
`timescale 1ns/1ns
`include "dssm_regs.vh"
module tb_display_source_select_and_monitor;
   localparam SCYC = 20;
   localparam LCYC = 60;
   localparam [31:0] EXT = 32'h1 << `DSSM_CTRL_EXT;
   localparam [31:0] CHK = 32'h1 << `DSSM_CTRL_CHECK;
   localparam [31:0] INS = 32'h1 << `DSSM_CTRL_IN;
   localparam [31:0] PRS = 32'h1 << `DSSM_CTRL_PRES;
   localparam [31:0] RCL = 32'h1 << `DSSM_CTRL_RECALL;
   localparam [31:0] INH = 32'h1 << `DSSM_CTRL_INHIBIT;
   localparam [31:0] SAV = 32'h1 << `DSSM_CTRL_SAVED;
   localparam [11:0] STA = `DSSM_ADDR_STAT;
   reg clk = 1'b0;
   reg nrst = 1'b0;
   reg psel = 1'b0, pen = 1'b0, pwr = 1'b0, ext_d = 1'b0, absent = 1'b0;
   reg [11:0] paddr = 12'h0;
   reg [31:0] pwdata = 32'h0;
   wire [31:0] prdata;
   wire pready, rclk, rdat, xclk, xdat, cclk, sdat, stb_n, load, fault;
   wire [7:0] ind;
   wire [3:0] uoe;
   integer err_count = 0, comparisons = 0, strobes = 0, cycles = 0;
   integer seed = 32'h2B31F86C;
   integer i, n;
   logic [31:0] exp_q[$];
   logic [31:0] r, w;
   logic [39:0] b;
   always #5 clk = ~clk;
   dssm_top #(.STROBE_CYC(SCYC), .LOSS_CYC(LCYC)) dut (
      .clock_in(clk), .nrst_in(nrst), .psel_in(psel), .penable_in(pen),
      .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(),
      .source_data_channel_zero_in(ext_d), .rev_data_in(rdat),
      .xfer_data_in(xdat), .store_data_in(sdat), .ctrl_clk_in(cclk),
      .rev_clk_in(rclk), .xfer_clk_in(xclk), .rev_data_absent_in(absent),
      .disp_data_out(), .disp_clk_out(), .disp_strobe_n_out(stb_n),
      .monitor_load_out(load), .line_fault_out(fault),
      .indicators_out(ind), .user_fn_out(), .user_fn_oe_out(uoe),
      .panel_disable_out());
   dssm_serial_model rev_m (.clk_out(rclk), .data_out(rdat));
   dssm_serial_model xfer_m (.clk_out(xclk), .data_out(xdat));
   dssm_serial_model ctl_m (.clk_out(cclk), .data_out(sdat));
   // ========
   // Shared tasks
   task check(input logic [31:0] seen, input logic [31:0] want);
      comparisons = comparisons + 1;
      if (seen !== want) begin
         err_count = err_count + 1;
         $display("[FAIL] %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task close_out;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      r = prdata;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task wr(input logic [31:0] d);
      apb(1'b1, `DSSM_ADDR_CTRL, d);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(r & m, e);
   endtask
   task code(input logic [2:0] c);
      rd(STA, 32'h7, {29'h0, c});
   endtask
   // Runs of ones kept short so only headers look like sync
   function logic [39:0] pay(input logic err);
      logic [63:0] v;
      v = {$random(seed), $random(seed)} & 64'hEE_EEEE_EEEE;
      v[15:12] = 4'h0;
      v[31] = err;
      return v[39:0];
   endfunction
   task mon(input logic [1:0] hc, input logic [39:0] d, input logic ld);
      if (ld)
         exp_q.push_back(d[31:0]);
      rev_m.send(hc, d);
      repeat (30) @(posedge clk);
   endtask
   task disp(input logic [1:0] src, input integer k);
      if (src == 2'h2)
         xfer_m.send(2'b10, pay(1'b0));
      else
         ctl_m.send(2'b01, pay(1'b0));
      repeat (30) @(posedge clk);
      check(strobes - n, k);
   endtask
   // ========
   // Watchers
   always @(negedge stb_n) if (nrst) strobes = strobes + 1;
   always @(posedge clk) ext_d <= ^$random(seed);
   always @(posedge clk) begin
      if (load === 1'b1) begin
         check({31'h0, exp_q.size() != 0}, 32'h1);
         w = exp_q.size() != 0 ? exp_q.pop_front() : 32'h0;
         repeat (3) @(posedge clk);
         check({28'h0, uoe}, {28'h0, w[19:16]});
         check({24'h0, ind}, {24'h0, w[31:28], w[25:23], w[21]});
         repeat (SCYC + 2) @(posedge clk);
         check({31'h0, fault}, {31'h0, w[31]});
      end
   end
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 30000) begin
         err_count = err_count + 1;
         $display("[FAIL] %0t run too long", $time);
         close_out;
      end
   end
   // ========
   // Main sequence
   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      rd(`DSSM_ADDR_CTRL, 32'hFFFF_FFFF, 32'h0);
      rd(STA, 32'h3F, 32'h28);
      check({30'h0, stb_n, load}, 32'h2);
      apb(1'b1, 12'h014, 32'hFFFF_FFFF);
      rd(12'h014, 32'hFFFF_FFFF, 32'h0);
      $display("reset test done");
      wr(EXT | PRS);
      rd(`DSSM_ADDR_CTRL, 32'h29, 32'h9);
      code(3'h6);
      wr(EXT | SAV);
      code(3'h1);
      wr(EXT | CHK);
      rd(STA, 32'h17, 32'h16);
      n = strobes;
      mon(2'b01, pay(1'b0), 1'b1);
      check(strobes - n, 0);
      wr(EXT | SAV);
      code(3'h3);
      mon(2'b10, pay(1'b1), 1'b1);
      check(strobes - n, 1);
      code(3'h1);
      wr(EXT | RCL);
      code(3'h7);
      disp(2'h3, 2);
      code(3'h1);
      wr(EXT | INS);
      code(3'h6);
      wr(EXT | INS | SAV);
      code(3'h5);
      disp(2'h2, 3);
      $display("select test done");
      mon(2'b00, pay(1'b0), 1'b0);
      b = pay(1'b0);
      b[13] = 1'b1;
      mon(2'b01, b, 1'b0);
      b[13] = 1'b0;
      b[39:34] = 6'h3E;
      mon(2'b01, b, 1'b0);
      absent <= 1'b1;
      mon(2'b01, pay(1'b0), 1'b0);
      absent <= 1'b0;
      b = pay(1'b0);
      mon(2'b10, b, 1'b1);
      rd(`DSSM_ADDR_LATCH, 32'hFFFF_FFFF, b[31:0]);
      $display("monitor test done");
      wr(EXT | INH);
      for (i = 0; i < 3; i++) mon(2'b01, pay(1'b0), i < 2);
      check(exp_q.size(), 0);
      $display("inhibit test done");
      close_out;
   end
endmodule // tb_display_source_select_and_monitor
